/* File: verilog/dmacc_pkg.sv */
// constants and types shared by the dma channel block
// assumes a single system clock; apb register bus with 32-bit data
package dmacc_pkg;

  // register byte offsets
  localparam logic [7:0] OFF_ORIGIN  = 8'h00; // channel_origin_pointer
  localparam logic [7:0] OFF_TARGET  = 8'h04; // channel_target_pointer
  localparam logic [7:0] OFF_NEXT    = 8'h08; // next_descriptor_pointer
  localparam logic [7:0] OFF_CONTROL = 8'h0C; // channel_control_word
  localparam logic [7:0] OFF_CONFIG  = 8'h10; // channel_configuration
  localparam logic [7:0] OFF_STATUS  = 8'h14; // enabled_channel_flags and sticky flags
  localparam logic [7:0] OFF_CLEAR   = 8'h18; // done_irq_clear

  // channel_configuration fields
  localparam int CFG_EN_BIT     = 0;
  localparam int CFG_ORIGIN_LO  = 1;
  localparam int CFG_TARGET_LO  = 6;
  localparam int CFG_DIR_LO     = 11;
  localparam int CFG_ERRIE_BIT  = 14;
  localparam int CFG_DONEIE_BIT = 15;
  localparam int CFG_LOCK_BIT   = 16;
  localparam int CFG_ACTIVE_BIT = 17;
  localparam int CFG_HOLD_BIT   = 18;
  localparam logic [31:0] CFG_WMASK = 32'h0005_FBDF;
  localparam logic [31:0] CFG_RESET = 32'h0000_0000;

  // transfer_direction codes
  localparam logic [2:0] DIR_M2M = 3'h0;
  localparam logic [2:0] DIR_M2P = 3'h1;
  localparam logic [2:0] DIR_P2M = 3'h2;

  // channel_control_word fields
  localparam int CTL_COUNT_LO = 0;
  localparam int CTL_COUNT_W  = 12;
  localparam int CTL_WIDTH_LO = 12;
  localparam int CTL_DONEIE_BIT = 31;
  localparam logic [31:0] CTL_RESET = 32'h0000_0000;

  // status and clear bits
  localparam int STS_ON_BIT   = 0;
  localparam int STS_DONE_BIT = 1;
  localparam int STS_ERR_BIT  = 2;
  localparam int STS_BUSY_BIT = 3;

  localparam logic [31:0] PTR_RESET = 32'h0000_0000;
  localparam logic [31:0] CHAIN_END = 32'h0000_0000;
  localparam logic [31:0] WORD_STEP = 32'h0000_0004;
  localparam logic [1:0]  DESC_LAST = 2'h3;

  typedef enum logic [5:0] {
    ST_IDLE = 6'b00_0001,
    ST_SRC  = 6'b00_0010,
    ST_RD   = 6'b00_0100,
    ST_DST  = 6'b00_1000,
    ST_WR   = 6'b01_0000,
    ST_LOAD = 6'b10_0000
  } dmacc_st_t;

  typedef struct packed {
    logic        req;
    logic        we;
    logic [1:0]  size;
    logic [31:0] addr;
    logic [31:0] wdata;
  } dmacc_mem_t;

endpackage

/* File: verilog/dmacc_req_sync.sv */
// two-stage synchroniser for the peripheral request lines
// assumes requests are asynchronous levels held until serviced
`timescale 1ns/100ps
`default_nettype none
module dmacc_req_sync import dmacc_pkg::*; (
  input  wire logic        i_clk,  // system clock
  input  wire logic        i_rst,  // async reset, active high
  input  wire logic [15:0] i_req,  // raw request pins
  output logic      [15:0] o_req   // synchronised requests
);
  logic [15:0] meta_reg;
  logic [15:0] sync_reg;

  genvar g;
  generate
    for (g = 0; g < 16; g++) begin : g_line
      always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
          meta_reg[g] <= 1'b0;
          sync_reg[g] <= 1'b0;
        end else begin
          meta_reg[g] <= i_req[g];
          sync_reg[g] <= meta_reg[g];
        end
      end
    end
  endgenerate

  assign o_req = sync_reg;
endmodule
`default_nettype wire

/* File: verilog/dmacc_step.sv */
// address alignment check and increment for one element width
// assumes width code 0 byte, 1 halfword, 2 word, 3 unusable
`timescale 1ns/100ps
`default_nettype none
module dmacc_step import dmacc_pkg::*; (
  input  wire logic [1:0]  i_size,    // element width code
  input  wire logic [31:0] i_addr,    // address to check
  output logic             o_aligned, // address fits the width
  output logic      [31:0] o_incr     // bytes per element
);
  always_comb begin
    o_incr = 32'h0000_0001 << i_size;
    case (i_size)
      2'h0:    o_aligned = 1'b1;
      2'h1:    o_aligned = ~i_addr[0];
      2'h2:    o_aligned = (i_addr[1:0] == 2'h0);
      default: o_aligned = 1'b0;
    endcase
  end
endmodule
`default_nettype wire

/* File: verilog/dmacc_channel.sv */
// one dma channel: configuration register, element mover and chain loader
// assumes an apb master for software and a simple req/ack memory bus
// Behaviour
// - bit 14 of configuration unmasks the error interrupt.
// - direction 000 mem-mem, 001 mem-periph, 010 periph-mem; others unused.
// - bits 9-6 pick the destination request line, ignored for memory.
// - bits 4-1 pick the source request line, ignored for memory.
// - bit 0 enables the channel; in mem-mem writing 1 starts it.
// - enable clears itself once the last block of the chain has moved.
// - disabling mid-transfer drops held data; software reinitialises channels.
// - mem-mem transfers never start from a hardware request line.
// - width/address mismatch sets the error flag; disable before rewriting settings.
// - after each block, reload pointers, count and width from next descriptor.
// - descriptor is four words: origin, target, next pointer, control.
// - block end raises completion interrupt when control word allows it.
// - a zero next-pointer ends the chain with no further fetch.
// - configuration bit 18 set makes the channel ignore peripheral requests.
// - read-only bit 17 shows whether the channel buffer holds data.
// - bit 15 unmasks the completion interrupt.
`timescale 1ns/100ps
`default_nettype none
module dmacc_channel import dmacc_pkg::*; (
  input  wire logic        i_clk,        // system clock, 20 MHz
  input  wire logic        i_rst,        // async reset, active high
  input  wire logic        psel,         // apb select
  input  wire logic        penable,      // apb access phase
  input  wire logic        pwrite,       // apb write
  input  wire logic [7:0]  paddr,        // apb byte address
  input  wire logic [31:0] pwdata,       // apb write data
  output logic      [31:0] prdata,       // apb read data
  output logic             pready,       // apb ready
  output logic             pslverr,      // apb error on unmapped address
  input  wire logic [15:0] i_periph_req, // peripheral request pins
  output logic             o_mem_req,    // memory access request
  output logic             o_mem_we,     // memory write
  output logic      [1:0]  o_mem_size,   // element width code
  output logic      [31:0] o_mem_addr,   // memory byte address
  output logic      [31:0] o_mem_wdata,  // memory write data
  output logic             o_mem_lock,   // bus lock, high only while a request is out and config bit 16 is set
  input  wire logic        i_mem_ack,    // access done this cycle
  input  wire logic        i_mem_err,    // access failed
  input  wire logic [31:0] i_mem_rdata,  // read data with ack
  output logic             o_done_irq,   // block completion interrupt
  output logic             o_err_irq     // error interrupt
);

  ////////////////////////////////////////////////////////////////////////////
  // state

  typedef struct packed {
    dmacc_st_t   st;
    logic [31:0] origin;
    logic [31:0] target;
    logic [31:0] next;
    logic [31:0] ctl;
    logic [31:0] cfg;
    logic [11:0] count;
    logic [31:0] buf_data;
    logic        buf_full;
    logic [1:0]  widx;
    logic        done_flag;
    logic        err_flag;
    logic [31:0] rdata;
    dmacc_mem_t  mem;
  } dmacc_state_t;

  dmacc_state_t state_reg;
  dmacc_state_t state_next;

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // register index 0..6, or 7 for an unmapped address
  function automatic logic [2:0] reg_index(input logic [7:0] a);
    case (a)
      OFF_ORIGIN:  reg_index = 3'd0;
      OFF_TARGET:  reg_index = 3'd1;
      OFF_NEXT:    reg_index = 3'd2;
      OFF_CONTROL: reg_index = 3'd3;
      OFF_CONFIG:  reg_index = 3'd4;
      OFF_STATUS:  reg_index = 3'd5;
      OFF_CLEAR:   reg_index = 3'd6;
      default:     reg_index = 3'd7;
    endcase
  endfunction

  // end of one block: flag it if the control word asks, then follow the chain or stop
  function automatic dmacc_state_t block_end(input dmacc_state_t s);
    dmacc_state_t t;
    t = s;
    if (s.ctl[CTL_DONEIE_BIT]) begin
      t.done_flag = 1'b1;
    end
    if (s.next == CHAIN_END) begin
      t.cfg[CFG_EN_BIT] = 1'b0;
      t.st = ST_IDLE;
    end else begin
      t.widx = 2'h0;
      t.mem.req = 1'b1;
      t.mem.we = 1'b0;
      t.mem.size = 2'h2;
      t.mem.addr = s.next;
      t.st = ST_LOAD;
    end
    return t;
  endfunction

  // error exit: drop the buffer and switch the channel off
  function automatic dmacc_state_t fail(input dmacc_state_t s);
    dmacc_state_t t;
    t = s;
    t.err_flag = 1'b1;
    t.cfg[CFG_EN_BIT] = 1'b0;
    t.buf_full = 1'b0;
    t.mem.req = 1'b0;
    t.st = ST_IDLE;
    return t;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // decode of configuration

  logic [15:0] req_sync;
  logic [2:0]  dir;
  logic        dir_ok;
  logic        src_is_per;
  logic        dst_is_per;
  logic        hold;
  logic        src_go;
  logic        dst_go;
  logic [1:0]  width;
  logic        src_aligned;
  logic        dst_aligned;
  logic [31:0] src_incr;
  logic [31:0] dst_incr;
  logic        enabled;

  dmacc_req_sync u_sync (
    .i_clk (i_clk),
    .i_rst (i_rst),
    .i_req (i_periph_req),
    .o_req (req_sync)
  );

  dmacc_step u_src_step (
    .i_size    (width),
    .i_addr    (state_reg.origin),
    .o_aligned (src_aligned),
    .o_incr    (src_incr)
  );

  dmacc_step u_dst_step (
    .i_size    (width),
    .i_addr    (state_reg.target),
    .o_aligned (dst_aligned),
    .o_incr    (dst_incr)
  );

  assign dir        = state_reg.cfg[CFG_DIR_LO +: 3];
  assign dir_ok     = (dir == DIR_M2M) || (dir == DIR_M2P) || (dir == DIR_P2M);
  assign src_is_per = (dir == DIR_P2M);
  assign dst_is_per = (dir == DIR_M2P);
  assign hold       = state_reg.cfg[CFG_HOLD_BIT];
  assign width      = state_reg.ctl[CTL_WIDTH_LO +: 2];
  assign enabled    = state_reg.cfg[CFG_EN_BIT];

  // memory sides run free; peripheral sides wait on their own line
  assign src_go = !src_is_per
                  || (req_sync[state_reg.cfg[CFG_ORIGIN_LO +: 4]] && !hold);
  assign dst_go = !dst_is_per
                  || (req_sync[state_reg.cfg[CFG_TARGET_LO +: 4]] && !hold);

  ////////////////////////////////////////////////////////////////////////////
  // next state

  logic        wr_acc;
  logic        setup;
  logic [2:0]  widx_sel;
  logic [31:0] cfg_view;
  logic [31:0] status_view;

  assign wr_acc   = psel && penable && pwrite;
  assign setup    = psel && !penable;
  assign widx_sel = reg_index(paddr);
  assign cfg_view = (state_reg.cfg & CFG_WMASK)
                    | ({31'h0000_0000, state_reg.buf_full} << CFG_ACTIVE_BIT);

  always_comb begin
    status_view = 32'h0000_0000;
    status_view[STS_ON_BIT]   = enabled;
    status_view[STS_DONE_BIT] = state_reg.done_flag;
    status_view[STS_ERR_BIT]  = state_reg.err_flag;
    status_view[STS_BUSY_BIT] = (state_reg.st != ST_IDLE);
  end

  always_comb begin
    state_next = state_reg;

    // read data is captured in the setup phase so prdata is a flop
    if (setup && !pwrite) begin
      case (reg_index(paddr))
        3'd0:    state_next.rdata = state_reg.origin;
        3'd1:    state_next.rdata = state_reg.target;
        3'd2:    state_next.rdata = state_reg.next;
        3'd3:    state_next.rdata = state_reg.ctl;
        3'd4:    state_next.rdata = cfg_view;
        3'd5:    state_next.rdata = status_view;
        default: state_next.rdata = 32'h0000_0000;
      endcase
    end

    // software writes come first so hardware events below win
    if (wr_acc) begin
      case (widx_sel)
        3'd0:    state_next.origin = pwdata;
        3'd1:    state_next.target = pwdata;
        3'd2:    state_next.next = pwdata;
        3'd3:    state_next.ctl = pwdata;
        3'd4:    state_next.cfg = pwdata & CFG_WMASK & ~(32'h0000_0001 << CFG_ACTIVE_BIT);
        3'd6: begin
          if (pwdata[STS_DONE_BIT]) begin
            state_next.done_flag = 1'b0;
          end
          if (pwdata[STS_ERR_BIT]) begin
            state_next.err_flag = 1'b0;
          end
        end
        default: ;
      endcase
    end

    case (state_reg.st)
      ST_IDLE: begin
        state_next.count = state_reg.ctl[CTL_COUNT_LO +: CTL_COUNT_W];
        // only the enable bit starts a channel; in mem-mem that is the start
        if (enabled && dir_ok) begin
          if (state_reg.ctl[CTL_COUNT_LO +: CTL_COUNT_W] == 12'h000) begin
            state_next = block_end(state_next);
          end else begin
            state_next.st = ST_SRC;
          end
        end
      end

      ST_SRC: begin
        if (!enabled) begin
          state_next.buf_full = 1'b0;
          state_next.st = ST_IDLE;
        end else if (src_go) begin
          if (!src_aligned) begin
            state_next = fail(state_next);
          end else begin
            state_next.mem.req = 1'b1;
            state_next.mem.we = 1'b0;
            state_next.mem.size = width;
            state_next.mem.addr = state_reg.origin;
            state_next.st = ST_RD;
          end
        end
      end

      ST_RD: begin
        if (i_mem_ack) begin
          state_next.mem.req = 1'b0;
          if (i_mem_err) begin
            state_next = fail(state_next);
          end else if (!enabled) begin
            state_next.buf_full = 1'b0;
            state_next.st = ST_IDLE;
          end else begin
            state_next.buf_data = i_mem_rdata;
            state_next.buf_full = 1'b1;
            if (!src_is_per) begin
              state_next.origin = state_reg.origin + src_incr;
            end
            state_next.st = ST_DST;
          end
        end
      end

      ST_DST: begin
        if (!enabled) begin
          state_next.buf_full = 1'b0;
          state_next.st = ST_IDLE;
        end else if (dst_go) begin
          if (!dst_aligned) begin
            state_next = fail(state_next);
          end else begin
            state_next.mem.req = 1'b1;
            state_next.mem.we = 1'b1;
            state_next.mem.size = width;
            state_next.mem.addr = state_reg.target;
            state_next.mem.wdata = state_reg.buf_data;
            state_next.st = ST_WR;
          end
        end
      end

      ST_WR: begin
        if (i_mem_ack) begin
          state_next.mem.req = 1'b0;
          state_next.mem.we = 1'b0;
          state_next.buf_full = 1'b0;
          if (i_mem_err) begin
            state_next = fail(state_next);
          end else begin
            if (!dst_is_per) begin
              state_next.target = state_reg.target + dst_incr;
            end
            state_next.count = state_reg.count - 12'h001;
            if (!enabled) begin
              state_next.st = ST_IDLE;
            end else if (state_reg.count == 12'h001) begin
              state_next = block_end(state_next);
            end else begin
              state_next.st = ST_SRC;
            end
          end
        end
      end

      ST_LOAD: begin
        // the four descriptor words arrive in a fixed order
        if (i_mem_ack) begin
          if (i_mem_err) begin
            state_next = fail(state_next);
          end else begin
            case (state_reg.widx)
              2'h0:    state_next.origin = i_mem_rdata;
              2'h1:    state_next.target = i_mem_rdata;
              2'h2:    state_next.next = i_mem_rdata;
              default: state_next.ctl = i_mem_rdata;
            endcase
            if (state_reg.widx == DESC_LAST) begin
              state_next.mem.req = 1'b0;
              state_next.count = i_mem_rdata[CTL_COUNT_LO +: CTL_COUNT_W];
              // an empty block goes back through idle to finish at once
              state_next.st = enabled ? ST_SRC : ST_IDLE;
              if (i_mem_rdata[CTL_COUNT_LO +: CTL_COUNT_W] == 12'h000) begin
                state_next.st = ST_IDLE;
              end
            end else begin
              state_next.widx = state_reg.widx + 2'h1;
              state_next.mem.addr = state_reg.mem.addr + WORD_STEP;
            end
          end
        end
      end

      default: begin
        state_next.st = ST_IDLE;
        state_next.mem.req = 1'b0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      state_reg.st        <= ST_IDLE;
      state_reg.origin    <= PTR_RESET;
      state_reg.target    <= PTR_RESET;
      state_reg.next      <= PTR_RESET;
      state_reg.ctl       <= CTL_RESET;
      state_reg.cfg       <= CFG_RESET;
      state_reg.count     <= 12'h000;
      state_reg.buf_data  <= 32'h0000_0000;
      state_reg.buf_full  <= 1'b0;
      state_reg.widx      <= 2'h0;
      state_reg.done_flag <= 1'b0;
      state_reg.err_flag  <= 1'b0;
      state_reg.rdata     <= 32'h0000_0000;
      state_reg.mem       <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign prdata      = state_reg.rdata;
  assign pready      = 1'b1;
  assign pslverr     = psel && penable && (widx_sel == 3'd7);
  assign o_mem_req   = state_reg.mem.req;
  assign o_mem_we    = state_reg.mem.we;
  assign o_mem_size  = state_reg.mem.size;
  assign o_mem_addr  = state_reg.mem.addr;
  assign o_mem_wdata = state_reg.mem.wdata;
  assign o_mem_lock  = state_reg.mem.req && state_reg.cfg[CFG_LOCK_BIT];
  assign o_done_irq  = state_reg.done_flag && state_reg.cfg[CFG_DONEIE_BIT];
  assign o_err_irq   = state_reg.err_flag && state_reg.cfg[CFG_ERRIE_BIT];

endmodule
`default_nettype wire

/* File: tb/dmacc_checker.sv */
// port-level assertions for the dma channel
// assumes software owns config bits 14, 15 and 18; hardware only clears bit 0
`timescale 1ns/100ps
`default_nettype none
module dmacc_checker import dmacc_pkg::*; (
  input wire logic        i_clk,       // clock
  input wire logic        i_rst,       // reset
  input wire logic        psel,        // apb
  input wire logic        penable,     // apb
  input wire logic        pwrite,      // apb
  input wire logic [7:0]  paddr,       // apb
  input wire logic [31:0] pwdata,      // apb
  input wire logic        o_mem_req,   // mem
  input wire logic        o_mem_we,    // mem
  input wire logic [31:0] o_mem_addr,  // mem
  input wire logic [31:0] o_mem_wdata, // mem
  input wire logic        i_mem_ack,   // mem
  input wire logic        i_mem_err,   // mem
  input wire logic [31:0] i_mem_rdata, // mem
  input wire logic        o_done_irq,  // irq
  input wire logic        o_err_irq    // irq
);
  // last config word written by software
  logic [31:0] cfg_reg;
  logic [31:0] rd_reg;
  logic [2:0]  dir;
  logic        held;
  assign dir = cfg_reg[13:11];
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      cfg_reg <= 32'h0000_0000;
      rd_reg  <= 32'h0000_0000;
    end else begin
      if (psel && penable && pwrite && paddr == OFF_CONFIG) cfg_reg <= pwdata;
      if (o_mem_req && i_mem_ack && !o_mem_we) rd_reg <= i_mem_rdata;
    end
  end
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) held <= 1'b0;
    else held <= cfg_reg[18];
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  ////////////////////////////////////////
  err_mask_a: assert property (o_err_irq |-> cfg_reg[14])
    else $error("error irq while masked");
  done_mask_a: assert property (o_done_irq |-> cfg_reg[15])
    else $error("done irq while masked");
  start_gate_a: assert property ($rose(o_mem_req) |-> cfg_reg[0])
    else $error("access without enable");
  hold_gate_a: assert property ($rose(o_mem_req) && held && cfg_reg[18]
    && (o_mem_we ? dir == DIR_M2P : dir == DIR_P2M) |-> 1'b0) else $error("paced access while held");
  desc_step_a: assert property (o_mem_req && i_mem_ack && !o_mem_we ##1 o_mem_req && !o_mem_we
    |-> o_mem_addr == $past(o_mem_addr) + WORD_STEP) else $error("descriptor word out of order");
  req_hold_a: assert property (o_mem_req && !i_mem_ack |=> o_mem_req && $stable(o_mem_addr))
    else $error("request dropped before ack");
  copy_data_a: assert property ($rose(o_mem_req) && o_mem_we |-> o_mem_wdata == rd_reg)
    else $error("written data differs from read");
  err_stop_a: assert property (o_mem_req && i_mem_ack && i_mem_err |=> !o_mem_req [*3])
    else $error("access after slave error");
  chain_c: cover property (o_mem_req && i_mem_ack && !o_mem_we ##1 o_mem_req && !o_mem_we);
  err_c: cover property (o_mem_req && i_mem_ack && i_mem_err);
  done_c: cover property ($rose(o_done_irq));
endmodule
bind dmacc_channel dmacc_checker i_dmacc_checker (.i_clk(i_clk), .i_rst(i_rst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .o_mem_req(o_mem_req),
  .o_mem_we(o_mem_we), .o_mem_addr(o_mem_addr), .o_mem_wdata(o_mem_wdata), .i_mem_ack(i_mem_ack),
  .i_mem_err(i_mem_err), .i_mem_rdata(i_mem_rdata), .o_done_irq(o_done_irq), .o_err_irq(o_err_irq));
`default_nettype wire

/* File: tb/dmacc_mem_model.sv */
// word memory answering the channel's master port
// assumes one access at a time; bench preloads mem by hierarchy
`timescale 1ns/100ps
`default_nettype none
module dmacc_mem_model import dmacc_pkg::*; (
  input  wire logic        i_clk,      // clock
  input  wire logic        i_rst,      // reset
  input  wire logic        i_req,      // request
  input  wire logic        i_we,       // write
  input  wire logic [31:0] i_addr,     // byte address
  input  wire logic [31:0] i_wdata,    // write data
  input  wire logic [1:0]  i_lat,      // extra wait cycles
  input  wire logic [31:0] i_err_addr, // address that fails
  output logic             o_ack,      // done
  output logic             o_err,      // failed
  output logic      [31:0] o_rdata     // read data
);
  logic [31:0] mem [0:255];
  logic [1:0]  wait_reg;
  int          n_acc = 0;
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_ack    <= 1'b0;
      o_err    <= 1'b0;
      o_rdata  <= 32'h5A5A_A5A5;
      wait_reg <= 2'h0;
    end else if (i_req && !o_ack && wait_reg == i_lat) begin
      o_ack    <= 1'b1;
      o_err    <= i_addr == i_err_addr;
      wait_reg <= 2'h0;
      n_acc    <= n_acc + 1;
      if (!i_we) o_rdata <= mem[i_addr[9:2]];
      else if (i_addr != i_err_addr) mem[i_addr[9:2]] <= i_wdata;
    end else begin
      // data is only valid with ack, so keep it moving otherwise
      o_ack   <= 1'b0;
      o_err   <= 1'b0;
      o_rdata <= ~o_rdata;
      if (i_req && !o_ack) wait_reg <= wait_reg + 2'h1;
    end
  end
endmodule
`default_nettype wire

/* File: tb/test_dmacc_channel.sv */
// bench for the dma channel: apb master, request lines, memory model
// assumes the checker binds itself to the channel
`timescale 1ns/100ps
`default_nettype none
module test_dmacc_channel import dmacc_pkg::*;;
  logic        i_clk, i_rst, psel, penable, pwrite, e;
  logic        pready, pslverr, mreq, mwe, ack, merr, done_irq, err_irq;
  logic [7:0]  paddr;
  logic [15:0] preq;
  logic [1:0]  lat;
  logic [31:0] pwdata, prdata, q, cfgv, err_a, maddr, mwd, mrd;
  int          fails, tests_run, seed, n, base;
  always #25 i_clk = ~i_clk;
  dmacc_channel i_dmacc_channel (.i_clk(i_clk), .i_rst(i_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .i_periph_req(preq), .o_mem_req(mreq), .o_mem_we(mwe), .o_mem_size(), .o_mem_addr(maddr),
    .o_mem_wdata(mwd), .o_mem_lock(), .i_mem_ack(ack), .i_mem_err(merr), .i_mem_rdata(mrd),
    .o_done_irq(done_irq), .o_err_irq(err_irq));
  dmacc_mem_model i_dmacc_mem_model (.i_clk(i_clk), .i_rst(i_rst), .i_req(mreq), .i_we(mwe),
    .i_addr(maddr), .i_wdata(mwd), .i_lat(lat), .i_err_addr(err_a), .o_ack(ack), .o_err(merr),
    .o_rdata(mrd));
  ////////////////////////////////////////
  task automatic stop_test;
    if (fails == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    tests_run++;
    if (g !== x) begin
      fails++;
      $display("CHECK FAILED at %0t: got %h, expected %h", $time, g, x);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge i_clk);
    penable <= 1'b1;
    do @(posedge i_clk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge i_clk);
  endtask
  task automatic wait_off;
    for (int i = 0; i < 300; i++) begin
      apb(1'b0, OFF_STATUS, 32'h0000_0000);
      if (q[STS_ON_BIT] === 1'b0) return;
    end
    chk(q, 32'h0000_0000);
  endtask
  // fills origin words at 0x100, poisons target words at 0x200
  task automatic prog(input logic [31:0] nxt);
    n = 1 + ($random(seed) & 3);
    lat <= $random(seed);
    for (int i = 0; i < 8; i++) begin
      i_dmacc_mem_model.mem[64 + i] = $random(seed);
      i_dmacc_mem_model.mem[128 + i] = ~i_dmacc_mem_model.mem[64 + i];
    end
    base = i_dmacc_mem_model.n_acc;
    apb(1'b1, OFF_ORIGIN, 32'h0000_0100);
    apb(1'b1, OFF_TARGET, 32'h0000_0200);
    apb(1'b1, OFF_NEXT, nxt);
    apb(1'b1, OFF_CONTROL, 32'h8000_2000 | n);
  endtask
  task automatic copied(input int s, input int d, input int c);
    for (int i = 0; i < c; i++) chk(i_dmacc_mem_model.mem[d + i], i_dmacc_mem_model.mem[s + i]);
  endtask
  ////////////////////////////////////////
  initial begin
    i_clk = 1'b0;
    i_rst = 1'b1;
    {psel, penable, pwrite, paddr, pwdata, preq, lat} = '0;
    err_a = 32'hFFFF_FFFF;
    {fails, tests_run} = '0;
    seed = 74;
    repeat (16) @(posedge i_clk);
    i_rst <= 1'b0;
    apb(1'b0, OFF_CONFIG, 32'h0000_0000);
    chk(q, CFG_RESET);
    apb(1'b0, 8'h1C, 32'h0000_0000);
    chk(e, 1);
    base = i_dmacc_mem_model.n_acc;
    apb(1'b1, OFF_CONFIG, 32'hFFFF_FFFF);
    apb(1'b0, OFF_CONFIG, 32'h0000_0000);
    chk(q, CFG_WMASK);
    preq <= $random(seed);
    apb(1'b1, OFF_CONFIG, 32'h0000_0000);
    repeat (10) @(posedge i_clk);
    chk(i_dmacc_mem_model.n_acc - base, 0);
    prog(CHAIN_END);
    apb(1'b1, OFF_CONFIG, 32'h0000_8001);
    wait_off;
    chk(i_dmacc_mem_model.n_acc - base, 2 * n);
    copied(64, 128, n);
    chk(done_irq, 1);
    apb(1'b1, OFF_CLEAR, 32'h0000_0002);
    chk(done_irq, 0);
    // second block lives at 0x40 and ends the chain
    i_dmacc_mem_model.mem[16] = 32'h0000_0300;
    i_dmacc_mem_model.mem[17] = 32'h0000_0380;
    i_dmacc_mem_model.mem[18] = CHAIN_END;
    i_dmacc_mem_model.mem[19] = 32'h8000_2002;
    for (int i = 0; i < 3; i++) i_dmacc_mem_model.mem[224 + i] = 32'hC0DE_0000 + i;
    i_dmacc_mem_model.mem[192] = $random(seed);
    i_dmacc_mem_model.mem[193] = $random(seed);
    prog(32'h0000_0040);
    apb(1'b1, OFF_CONFIG, 32'h0000_0001);
    wait_off;
    chk(i_dmacc_mem_model.n_acc - base, 2 * n + 8);
    copied(64, 128, n);
    copied(192, 224, 2);
    chk(i_dmacc_mem_model.mem[226], 32'hC0DE_0002);
    chk(done_irq, 0);
    apb(1'b0, OFF_STATUS, 32'h0000_0000);
    chk(q[STS_DONE_BIT], 1);
    apb(1'b1, OFF_CLEAR, 32'h0000_0002);
    // paced directions, first held then released
    for (int j = 0; j < 2; j++) begin
      prog(CHAIN_END);
      cfgv = $random(seed) & 15;
      cfgv = 32'h0004_0001 | (j ? (32'h1 << 11) | (cfgv << 6) : (32'h2 << 11) | (cfgv << 1));
      preq <= 16'h0001 << (j ? cfgv[9:6] : cfgv[4:1]);
      apb(1'b1, OFF_CONFIG, cfgv);
      repeat (20) @(posedge i_clk);
      chk(i_dmacc_mem_model.n_acc - base, j);
      apb(1'b0, OFF_CONFIG, 32'h0000_0000);
      chk(q[CFG_ACTIVE_BIT], j);
      apb(1'b1, OFF_CONFIG, cfgv & 32'hFFFB_FFFF);
      wait_off;
      chk(i_dmacc_mem_model.n_acc - base, 2 * n);
      for (int i = 0; i < (j ? 1 : n); i++) copied(j ? 63 + n : 64, 128 + i, 1);
      preq <= 16'h0000;
    end
    prog(CHAIN_END);
    apb(1'b1, OFF_ORIGIN, 32'h0000_0102);
    apb(1'b1, OFF_CONFIG, 32'h0000_4001);
    wait_off;
    chk(err_irq, 1);
    apb(1'b1, OFF_CLEAR, 32'h0000_0004);
    chk(err_irq, 0);
    err_a <= 32'h0000_0100;
    prog(CHAIN_END);
    apb(1'b1, OFF_CONFIG, 32'h0000_0001);
    wait_off;
    chk(i_dmacc_mem_model.n_acc - base, 1);
    chk(err_irq, 0);
    apb(1'b0, OFF_STATUS, 32'h0000_0000);
    chk(q[STS_ERR_BIT], 1);
    stop_test;
  end
  initial begin
    repeat (20000) @(posedge i_clk);
    fails++;
    stop_test;
  end
endmodule
`default_nettype wire
